// file: inc/fna_pkg.sv
// fna_pkg: constants and carrier types for the fieldbus node address config
`default_nettype none
package fna_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam logic [7:0]  REG_NODE_STAT = 8'h00;
  localparam logic [7:0]  REG_LINK_CTRL = 8'h04;
  localparam logic [7:0]  REG_LINK_STAT = 8'h08;

  // node status fields
  localparam int          NS_ADDR_LSB   = 0;
  localparam int          NS_DIS_BIT    = 8;
  localparam int          NS_DIP_LSB    = 9;
  localparam int          NS_ROT_LSB    = 16;

  // link status fields
  localparam int          LS_PERM_LSB   = 0;
  localparam int          LS_RETRY_LSB  = 8;
  localparam int          LS_CFGOK_BIT  = 16;
  localparam int          LS_SYNC_BIT   = 17;
  localparam int          LS_LOST_BIT   = 18;

  // ----------------------------------------------------------------
  // node address formation
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_BASE_LO  = 8'h40;
  localparam logic [7:0]  ADDR_BASE_HI  = 8'h50;
  localparam logic [3:0]  ROT_DISABLE   = 4'h0;
  localparam int          DIP_RANGE_BIT = 2;

  // ----------------------------------------------------------------
  // cycle time table, code is the cycle in 0.25 ms units
  // ----------------------------------------------------------------
  localparam logic [5:0]  CODE_MAX      = 6'h20;
  localparam logic [5:0]  CODE_0P25     = 6'h01;
  localparam logic [5:0]  CODE_0P5      = 6'h02;
  localparam logic [5:0]  CODE_1P0      = 6'h04;
  localparam logic [5:0]  CODE_1P5      = 6'h06;
  localparam logic [5:0]  CODE_2P0      = 6'h08;
  localparam logic [5:0]  CODE_2P5      = 6'h0A;
  localparam logic [5:0]  CODE_3P0      = 6'h0C;
  localparam logic [4:0]  SLV_0P25      = 5'h00;
  localparam logic [4:0]  SLV_0P5       = 5'h03;
  localparam logic [4:0]  SLV_1P0       = 5'h08;
  localparam logic [4:0]  SLV_1P5       = 5'h0E;
  localparam logic [4:0]  SLV_2P0       = 5'h14;
  localparam logic [4:0]  SLV_2P5       = 5'h19;
  localparam logic [4:0]  SLV_MAX       = 5'h1E;

  // frame data lengths in bytes
  localparam logic [5:0]  LEN_SHORT     = 6'h11;
  localparam logic [5:0]  LEN_LONG      = 6'h20;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          T_UNIT_NS     = 250000;
  localparam int          UNIT_CYCLES   = T_UNIT_NS / CLK_PERIOD_NS;

  // reset value of the link control register: 1.0 ms, 17 bytes, one slave
  localparam logic [31:0] LINK_CTRL_RST = 32'h0201_0004;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] dip;
    logic [3:0] rotary;
  } fna_strap_t;

  typedef struct packed {
    logic [7:0]  comm_mult;
    logic [2:0]  rsv_hi;
    logic [4:0]  attached;
    logic [6:0]  rsv_lo;
    logic        sec_master;
    logic        no_retry;
    logic        len_long;
    logic [5:0]  cycle_code;
  } fna_link_cfg_t;

  typedef struct packed {
    logic [4:0] permitted;
    logic [4:0] retries;
    logic       cfg_ok;
  } fna_slot_t;

endpackage
`default_nettype wire

// file: core/fna_slot_calc.sv
// fna_slot_calc: permitted slave count, retry count and link config check
`timescale 1ns/10ps
`default_nettype none
module fna_slot_calc
(
  // configuration
  input  wire fna_pkg::fna_link_cfg_t i_cfg,
  // result
  output var  fna_pkg::fna_slot_t     o_slot
);
  import fna_pkg::*;

  // table lookup, odd codes fall back to the next lower listed time
  function automatic logic [4:0] base_count(input logic [5:0] code);
    if (code >= CODE_3P0)      base_count = SLV_MAX;
    else if (code >= CODE_2P5) base_count = SLV_2P5;
    else if (code >= CODE_2P0) base_count = SLV_2P0;
    else if (code >= CODE_1P5) base_count = SLV_1P5;
    else if (code >= CODE_1P0) base_count = SLV_1P0;
    else if (code >= CODE_0P5) base_count = SLV_0P5;
    else                       base_count = SLV_0P25;
  endfunction

  logic [4:0] base;
  logic [4:0] perm;
  logic       code_ok;
  logic       mult_ok;

  // count of slaves the chosen cycle allows
  always_comb
  begin
    base = base_count(i_cfg.cycle_code);                    // [R5]
    perm = base;
    if (i_cfg.sec_master)                                   // [R10]
      perm = (perm == 5'h00) ? 5'h00 : perm - 5'h01;
    if (i_cfg.no_retry)                                     // [R9]
      perm = perm + 5'h01;
  end

  // legal codes are 0.25 ms, 0.5 ms and whole even steps up to 8 ms
  always_comb
  begin
    code_ok = (i_cfg.cycle_code == CODE_0P25) ||
              ((i_cfg.cycle_code != 6'h00) &&
               !i_cfg.cycle_code[0] && (i_cfg.cycle_code <= CODE_MAX));
    // fastest cycle needs a comm cycle of whole 0.5 ms steps
    mult_ok = (i_cfg.cycle_code != CODE_0P25) ||
              ((i_cfg.comm_mult != 8'h00) && !i_cfg.comm_mult[0]); // [R6]
  end

  // spare slots turn into retries, none when retries are off
  always_comb
  begin
    o_slot.permitted = perm;
    o_slot.cfg_ok    = code_ok && mult_ok && (i_cfg.attached <= perm);
    if (i_cfg.no_retry || (i_cfg.attached > perm))
      o_slot.retries = 5'h00;
    else
      o_slot.retries = perm - i_cfg.attached + 5'h01;       // [R7] [R8]
  end

endmodule
`default_nettype wire

// file: core/fna_node_cfg.sv
// fna_node_cfg: node address latch, link setup and cycle sync watch
//
// Overview of operation
// (R1) With the range bit off the address is 40h plus the rotary value, and rotary 0 disables the node.
// (R2) With the range bit on the address is 50h plus the rotary value, covering 50h to 5Fh.
// (R3) The switches are sampled once after power-up reset and later changes are ignored.
// (R4) Factory switches (range off, rotary 1) give address 41h.
// (R5) Permitted slaves per cycle time are 0, 3, 8, 14, 20, 25 and 30 from 0.25 ms to 3.0 ms and up.
// (R6) At a 0.25 ms cycle the master keeps the comm cycle a whole multiple of 0.5 ms.
// (R7) Unused slave slots may serve the master as retry slots.
// (R8) Retries equal permitted slaves minus attached slaves plus one.
// (R9) With retries off one more slave than normal is permitted.
// (R10) A secondary master station on the bus cuts the permitted count by one.
// (R11) The frame data field is 17 or 32 bytes and both ends use the same.
// (R12) Each exchange of this node follows the master's cyclic timing.
// (R13) The latched address and disabled flag stay stable and feed address match.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module fna_node_cfg
#(
  parameter int UNIT_CYC = fna_pkg::UNIT_CYCLES
)
(
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_sys_rst,
  // switches
  input  wire logic [3:0]                 i_rotary_address_switch,
  input  wire logic [3:0]                 i_link_config_dip_switch,
  // register port
  input  wire logic [fna_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic [fna_pkg::DATA_W-1:0] i_reg_wdata,
  input  wire logic                       i_reg_wr,
  input  wire logic                       i_reg_rd,
  output logic      [fna_pkg::DATA_W-1:0] o_reg_rdata,
  // frame side
  input  wire logic                       i_cyc_sync,
  input  wire logic                       i_rx_addr_vld,
  input  wire logic [7:0]                 i_rx_addr,
  output logic                            o_addr_hit,
  output logic      [7:0]                 o_node_addr,
  output logic                            o_node_disabled,
  output logic      [5:0]                 o_frame_len,
  output logic                            o_sync_ok
);
  import fna_pkg::*;

  // ----------------------------------------------------------------
  // switch latch
  // ----------------------------------------------------------------

  fna_strap_t    strap_q;
  logic          strap_done_q;
  logic [7:0]    node_addr_q;
  logic          node_dis_q;
  logic [7:0]    node_addr_d;
  logic          node_dis_d;

  // base plus rotary value; both bases have a zero low nibble, so the
  // rotary value drops in with no carry into the upper nibble
  function automatic logic [7:0] form_addr(input logic       range_on,
                                           input logic [3:0] rot);
    if (range_on)
      form_addr = ADDR_BASE_HI | {4'h0, rot};               // [R2]
    else
      form_addr = ADDR_BASE_LO | {4'h0, rot};               // [R1] [R4]
  endfunction

  // only the low range has a disabled setting; rotary zero in the high
  // range is an ordinary address
  function automatic logic is_off(input logic       range_on,
                                  input logic [3:0] rot);
    is_off = !range_on && (rot == ROT_DISABLE);             // [R1]
  endfunction

  // address and disable flag from the switches, read by the latch only
  always_comb
  begin
    node_addr_d = form_addr(i_link_config_dip_switch[DIP_RANGE_BIT],
                            i_rotary_address_switch);
    node_dis_d  = is_off(i_link_config_dip_switch[DIP_RANGE_BIT],
                         i_rotary_address_switch);
  end

  // capture once, on the first edge after reset is released; the switch
  // pins are not read again, so a change while running waits for power-up;
  // a mid-run reset reads them afresh, as a power cycle would
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      strap_done_q <= 1'b0;
      strap_q      <= '0;
      node_addr_q  <= 8'h00;
      node_dis_q   <= 1'b1;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;                                 // [R3]
      strap_q      <= {i_link_config_dip_switch, i_rotary_address_switch};
      node_addr_q  <= node_addr_d;                          // [R13]
      node_dis_q   <= node_dis_d;                           // [R13]
    end
  end

  // ----------------------------------------------------------------
  // link control register
  // ----------------------------------------------------------------

  fna_link_cfg_t link_cfg_q;
  fna_slot_t     slot;
  logic          wr_ctrl;
  logic          wr_stat;

  // write decodes; the node status word is read-only, so a write there
  // is dropped
  assign wr_ctrl = i_reg_wr && (i_reg_addr == REG_LINK_CTRL);
  assign wr_stat = i_reg_wr && (i_reg_addr == REG_LINK_STAT);

  // reserved fields are cleared on the way in, so a read shows zero there
  // whatever software wrote and no later decode can trip over them
  function automatic fna_link_cfg_t clean_ctrl(input logic [DATA_W-1:0] w);
    fna_link_cfg_t c;
    c          = fna_link_cfg_t'(w);
    c.rsv_hi   = 3'h0;
    c.rsv_lo   = 7'h00;
    clean_ctrl = c;
  endfunction

  // control register, written whole; there are no byte lanes
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      link_cfg_q <= fna_link_cfg_t'(LINK_CTRL_RST);
    else if (wr_ctrl)
      link_cfg_q <= clean_ctrl(i_reg_wdata);                // [R11]
  end

  // permitted count and retries; combinational from the control register,
  // so a write shows in the status word at the very next read
  fna_slot_calc u_slot
  (
    .i_cfg  (link_cfg_q),
    .o_slot (slot)
  );

  // ----------------------------------------------------------------
  // 0.25 ms unit tick
  // ----------------------------------------------------------------

  localparam int DIV_W = $clog2(UNIT_CYC);

  logic [DIV_W-1:0] div_q;
  logic             unit_tick;

  assign unit_tick = (div_q == DIV_W'(UNIT_CYC - 1));

  // free-running divider, one enable pulse per 0.25 ms; it is not aligned
  // to the master, which is why the sync watch below allows one unit of
  // slack
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || unit_tick)
      div_q <= '0;
    else
      div_q <= div_q + DIV_W'(1);
  end

  // ----------------------------------------------------------------
  // cycle sync watch
  // ----------------------------------------------------------------

  logic [6:0] unit_cnt_q;
  logic       sync_ok_q;
  logic       sync_lost_q;
  logic       sync_late;

  // one unit of slack allows for the divider phase against the master;
  // a master that stops sending is seen late at the first tick past it
  assign sync_late = unit_tick &&
                     (unit_cnt_q > {1'b0, link_cfg_q.cycle_code});

  // units since the last master cycle start; the count saturates, so a
  // long silence cannot wrap back into the legal range
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || i_cyc_sync)
      unit_cnt_q <= 7'h00;
    else if (unit_tick && (unit_cnt_q != 7'h7F))
      unit_cnt_q <= unit_cnt_q + 7'h01;
  end

  // in sync from the first master cycle start until one is missed;
  // a lost lock is not fatal, the next cycle start locks again
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      sync_ok_q <= 1'b0;
    else if (i_cyc_sync)
      sync_ok_q <= 1'b1;                                    // [R12]
    else if (sync_late)
      sync_ok_q <= 1'b0;                                    // [R12]
  end

  // sticky loss flag, write one to clear; a loss in the clear cycle stays;
  // clearing while the master is still silent does not set it again,
  // since a loss is only counted while locked
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      sync_lost_q <= 1'b0;
    else if (sync_late && sync_ok_q)
      sync_lost_q <= 1'b1;
    else if (wr_stat && i_reg_wdata[LS_LOST_BIT])
      sync_lost_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // address match
  // ----------------------------------------------------------------

  logic rx_match;
  logic node_live;

  // the slow conditions in one place; a frame that arrives while any of
  // them is missing is dropped silently, with no error reply
  assign node_live = strap_done_q && !node_dis_q && slot.cfg_ok && sync_ok_q;
  assign rx_match  = i_rx_addr_vld && (i_rx_addr == node_addr_q); // [R13]

  // answer only when enabled, configured and locked to the master cycle
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_addr_hit <= 1'b0;
    else
      o_addr_hit <= rx_match && node_live;                  // [R12] [R13]
  end

  // frame length follows the control register; the master must match it
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_frame_len <= LEN_SHORT;
    else
      o_frame_len <= link_cfg_q.len_long ? LEN_LONG : LEN_SHORT; // [R11]
  end

  // outputs of the latched address, which move only at reset and at the
  // single capture edge after it, and of the sync flag, which does not
  assign o_node_addr     = node_addr_q;                     // [R13]
  assign o_node_disabled = node_dis_q;
  assign o_sync_ok       = sync_ok_q;

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------

  logic [DATA_W-1:0] rd_d;

  // unmapped offsets read as zero; reads have no side effects, so a stray
  // read strobe cannot disturb any flag
  always_comb
  begin
    rd_d = '0;
    unique case (i_reg_addr)
      REG_NODE_STAT:
      begin
        rd_d[NS_ADDR_LSB +: 8] = node_addr_q;
        rd_d[NS_DIS_BIT]       = node_dis_q;
        rd_d[NS_DIP_LSB +: 4]  = strap_q.dip;
        rd_d[NS_ROT_LSB +: 4]  = strap_q.rotary;
      end
      REG_LINK_CTRL:
        rd_d = DATA_W'(link_cfg_q);
      REG_LINK_STAT:
      begin
        rd_d[LS_PERM_LSB +: 5]  = slot.permitted;
        rd_d[LS_RETRY_LSB +: 5] = slot.retries;
        rd_d[LS_CFGOK_BIT]      = slot.cfg_ok;
        rd_d[LS_SYNC_BIT]       = sync_ok_q;
        rd_d[LS_LOST_BIT]       = sync_lost_q;
      end
      default:
        rd_d = '0;
    endcase
  end

  // data stand only in the cycle after the read strobe and drop to zero
  // after it, so a late sample cannot pick up stale data
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !i_reg_rd)
      o_reg_rdata <= '0;
    else
      o_reg_rdata <= rd_d;
  end

endmodule
`default_nettype wire

// file: bench/fna_node_cfg_sva.sv
// fna_node_cfg_sva: port-level assertions for the node config block
`timescale 1ns/10ps
`default_nettype none
module fna_node_cfg_sva
  import fna_pkg::*;
#(
  parameter int UNIT_CYC = 10
)
(
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  // switches and register port
  input wire logic [3:0]  i_rotary_address_switch,
  input wire logic [3:0]  i_link_config_dip_switch,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  // frame side
  input wire logic        i_cyc_sync,
  input wire logic        i_rx_addr_vld,
  input wire logic [7:0]  i_rx_addr,
  input wire logic        o_addr_hit,
  input wire logic [7:0]  o_node_addr,
  input wire logic        o_node_disabled,
  input wire logic [5:0]  o_frame_len,
  input wire logic        o_sync_ok
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_hit_addr;
    o_addr_hit |-> $past(i_rx_addr_vld) && $past(i_rx_addr) == o_node_addr;
  endproperty
  a_hit_addr: assert property (p_hit_addr)
    else $error("addr hit for a foreign address");

  // a hit needs a live node locked to the master cycle
  property p_hit_gate;
    o_addr_hit |-> !o_node_disabled && $past(o_sync_ok);
  endproperty
  a_hit_gate: assert property (p_hit_gate)
    else $error("addr hit while disabled or unsynced");

  // switches seen at the first edge after release form the address
  property p_capture;
    $past(i_sys_rst, 2) && !$past(i_sys_rst) |->
      o_node_disabled == (!$past(i_link_config_dip_switch[DIP_RANGE_BIT])
        && $past(i_rotary_address_switch) == ROT_DISABLE)
      && (o_node_disabled || o_node_addr ==
        ($past(i_link_config_dip_switch[DIP_RANGE_BIT]) ? ADDR_BASE_HI
          : ADDR_BASE_LO) + {4'h0, $past(i_rotary_address_switch)});
  endproperty
  a_capture: assert property (p_capture)
    else $error("node address not formed from switches");

  property p_stable;
    !$past(i_sys_rst) && !$past(i_sys_rst, 2) |->
      $stable(o_node_addr) && $stable(o_node_disabled);
  endproperty
  a_stable: assert property (p_stable)
    else $error("node address moved after capture");

  property p_rd_idle;
    !$past(i_reg_rd) |-> o_reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");

  property p_nstat;
    $past(i_reg_rd) && !$past(i_sys_rst, 2)
      && $past(i_reg_addr) == REG_NODE_STAT
      |-> o_reg_rdata[8:0] == {o_node_disabled, o_node_addr};
  endproperty
  a_nstat: assert property (p_nstat)
    else $error("node status read disagrees with outputs");

  property p_len;
    i_reg_wr && i_reg_addr == REG_LINK_CTRL && i_reg_wdata[6]
      |-> ##[1:2] o_frame_len == LEN_LONG;
  endproperty
  a_len: assert property (p_len)
    else $error("long frame length not applied");

  property p_sync_set;
    i_cyc_sync |=> o_sync_ok [*2];
  endproperty
  a_sync_set: assert property (p_sync_set)
    else $error("sync flag not set by cycle start");
endmodule
`default_nettype wire

// file: bench/fna_master_model.sv
// fna_master_model: master stand-in that issues cycle syncs and frames
`timescale 1ns/10ps
`default_nettype none
module fna_master_model
#(
  parameter int PER = 30
)
(
  // clock and control
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_run,
  input  wire logic [7:0] i_dest,
  // bus side
  output var  logic       o_sync,
  output var  logic       o_vld,
  output var  logic [7:0] o_addr
);
  int cnt_q;
  // cycle timer; every frame rides on this cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_run)
      cnt_q <= 0;
    else
      cnt_q <= (cnt_q == PER - 1) ? 0 : cnt_q + 1;
  end
  // frame address one cycle after sync; idle line toggles so a stale
  // address never looks valid
  always_ff @(posedge i_clk)
  begin
    o_sync <= i_run && !i_rst && cnt_q == PER - 1;
    o_vld  <= o_sync && !i_rst;
    o_addr <= i_rst ? 8'h5A : (o_sync ? i_dest : ~o_addr);
  end
endmodule
`default_nettype wire

// file: bench/fna_node_cfg_bench.sv
// fna_node_cfg_bench: self-checking bench for the node config block
`timescale 1ns/10ps
`default_nettype none
module fna_node_cfg_bench;
  import fna_pkg::*;
  logic        clk, rst, wr, rd, run, sync, vld, hit, dis, sok;
  logic [3:0]  rot, dip;
  logic [7:0]  addr, rxa, node, dest;
  logic [31:0] wdat, rdat;
  logic [5:0]  flen;
  int          n_fail, tests_run, nv, nh;
  int          hits = 0;
  int          vlds = 0;
  // link setups (comm multiple kept even for the short cycle except in entry 11, which is odd)
  localparam logic [31:0] CFG [13] = '{32'h0200_0001, 32'h0200_0002,
    32'h0200_0004, 32'h0200_0006, 32'h0200_0008, 32'h0200_000A,
    32'h0200_000C, 32'h0200_0020, 32'h0200_0084, 32'h0200_0104,
    32'h0203_0004, 32'h0100_0001, 32'h0209_0004};
  // permitted, retries, cfg ok
  localparam logic [31:0] EXP [13] = '{32'h1_0100, 32'h1_0403,
    32'h1_0908, 32'h1_0F0E, 32'h1_1514, 32'h1_1A19, 32'h1_1F1E,
    32'h1_1F1E, 32'h1_0009, 32'h1_0807, 32'h1_0608, 32'h0_0100,
    32'h0_0008};

  fna_node_cfg #(.UNIT_CYC(10)) dut (.i_clk(clk), .i_sys_rst(rst),
    .i_rotary_address_switch(rot), .i_link_config_dip_switch(dip),
    .i_reg_addr(addr), .i_reg_wdata(wdat), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdat), .i_cyc_sync(sync), .i_rx_addr_vld(vld),
    .i_rx_addr(rxa), .o_addr_hit(hit), .o_node_addr(node),
    .o_node_disabled(dis), .o_frame_len(flen), .o_sync_ok(sok));
  fna_master_model #(.PER(30)) u_mst (.i_clk(clk), .i_rst(rst),
    .i_run(run), .i_dest(dest), .o_sync(sync), .o_vld(vld), .o_addr(rxa));

  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr   <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    wr   <= 1'b0;
  endtask
  // read data only stands in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] m, e,
                        input string nm);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(nm, e, rdat & m);
  endtask
  // reset with given switches, then move them to prove they are ignored
  task automatic boot(input logic [3:0] r, d);
    @(posedge clk);
    rst <= 1'b1;
    rot <= r;
    dip <= d;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rot <= ~r;
    dip <= ~d;
    @(posedge clk);
    #1;
  endtask
  // let the master run for a while, then stop it
  task automatic frames(input logic [7:0] d, input int n);
    dest <= d;
    run  <= 1'b1;
    repeat (n) @(posedge clk);
    run  <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic close_out;
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // frame and hit counters
  always @(posedge clk)
  begin
    if (hit === 1'b1)
      hits <= hits + 1;
    if (vld === 1'b1)
      vlds <= vlds + 1;
  end
  // a hang is cut short well beyond the expected run length
  initial
  begin
    repeat (6000) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial
  begin
    {rst, wr, rd, run} = 4'h8;
    {rot, dip, addr, dest, wdat} = '0;
    {n_fail, tests_run} = '0;
    for (int i = 0; i < 32; i++)
    begin
      boot(i[3:0], {1'b0, i[4], 2'b11});
      chk("disabled", {31'h0, i == 0}, {31'h0, dis});
      if (i != 0)
        chk("node_addr", {24'h0, (i[4] ? 8'h50 : 8'h40) + {4'h0, i[3:0]}},
            {24'h0, node});
    end
    // disabled node stays silent, even to its own switch address
    boot(4'h0, 4'h3);
    nv = hits;
    frames(node, 100);
    chk("dis_hits", nv, hits);
    boot(4'h1, 4'h3);
    chk("factory", 32'h41, {24'h0, node});
    chk("len_rst", 32'h11, {26'h0, flen});
    rd_reg(REG_NODE_STAT, 32'hF_1FFF, 32'h1_0641, "node_stat");
    rd_reg(REG_LINK_CTRL, '1, LINK_CTRL_RST, "ctrl_rst");
    rd_reg(8'hFC, '1, 32'h0, "unmapped");
    wr_reg(REG_LINK_CTRL, 32'hFFFF_FFFF);
    rd_reg(REG_LINK_CTRL, '1, 32'hFF1F_01FF, "ctrl_rsv");
    chk("len_long", 32'h20, {26'h0, flen});
    for (int i = 0; i < 13; i++)
    begin
      wr_reg(REG_LINK_CTRL, CFG[i]);
      rd_reg(REG_LINK_STAT, 32'h1_1F1F, EXP[i], "slots");
    end
    wr_reg(REG_LINK_CTRL, LINK_CTRL_RST);
    // own address hits once per frame, a neighbour's never
    nv = vlds;
    nh = hits;
    frames(8'h41, 200);
    chk("hits", vlds - nv, hits - nh);
    chk("frames", 32'h1, {31'h0, vlds > nv + 4});
    nh = hits;
    frames(8'h42, 100);
    chk("foreign", nh, hits);
    // master silent: lock drops and the sticky loss flag clears on write
    repeat (100) @(posedge clk);
    #1 chk("sync_ok", 32'h0, {31'h0, sok});
    rd_reg(REG_LINK_STAT, 32'h6_0000, 32'h4_0000, "lost");
    wr_reg(REG_LINK_STAT, 32'h4_0000);
    rd_reg(REG_LINK_STAT, 32'h6_0000, 32'h0, "lost_clr");
    close_out();
  end
endmodule

bind fna_node_cfg fna_node_cfg_sva #(.UNIT_CYC(UNIT_CYC)) u_sva (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_rotary_address_switch(i_rotary_address_switch),
  .i_link_config_dip_switch(i_link_config_dip_switch),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .i_cyc_sync(i_cyc_sync), .i_rx_addr_vld(i_rx_addr_vld),
  .i_rx_addr(i_rx_addr), .o_addr_hit(o_addr_hit),
  .o_node_addr(o_node_addr), .o_node_disabled(o_node_disabled),
  .o_frame_len(o_frame_len), .o_sync_ok(o_sync_ok));
`default_nettype wire
